//--- hw/port_io_regs.vh
/*
  port_io_regs.vh: register addresses, reset values and field positions
  for the port configuration and crossbar block.
  assumes: included by bare name from design files under hw/.
*/
`ifndef PORT_IO_REGS_VH
`define PORT_IO_REGS_VH

// special-function-register addresses (8-bit address space)
`define ADDR_PORT0_COMPARE_VALUE    8'hfd
`define ADDR_PORT1_COMPARE_VALUE    8'hed
`define ADDR_PORT0_COMPARE_SELECT   8'hfe
`define ADDR_PORT1_COMPARE_SELECT   8'hee
`define ADDR_PORT0_INPUT_KIND       8'hf1
`define ADDR_PORT1_INPUT_KIND       8'hf2
`define ADDR_PORT0_DRIVER_KIND      8'ha4
`define ADDR_PORT1_DRIVER_KIND      8'ha5
`define ADDR_PORT0_ROUTE_BYPASS     8'hd4
`define ADDR_PORT1_ROUTE_BYPASS     8'hd5
`define ADDR_ROUTE_MATRIX_CFG_A     8'he1
`define ADDR_ROUTE_MATRIX_CFG_B     8'he2
`define ADDR_ROUTE_MATRIX_CFG_C     8'he3
`define ADDR_PORT0_DATA             8'h80
`define ADDR_PORT1_DATA             8'h90

// reset values
`define RST_COMPARE_VALUE           8'hff
`define RST_COMPARE_SELECT          8'h00
`define RST_INPUT_KIND              8'hff
`define RST_DRIVER_KIND             8'h00
`define RST_ROUTE_BYPASS            8'h00
`define RST_MATRIX_CFG              8'h00
`define RST_PORT_DATA               8'hff
`define RST_PIN_LEVEL               16'hffff
`define RST_PAD_LEVEL               16'hffff
`define RST_PAD_OE_N                16'hffff
`define RST_PAD_PULLUP              16'h0000
`define RST_PAD_ANALOG              16'h0000

// field positions
`define BIT_PULLUP_OFF              7
`define BIT_ROUTE_MATRIX_ON         6

`endif

//--- hw/port_io_crossbar_config.v
/*
  port_io_crossbar_config.v: port input/output mode, weak pull-up,
  crossbar enable and skip, and port 0/1 match comparison logic.
  assumes: cpu drives sfr_addr_i/sfr_wdata_i with a one-cycle sfr_wr_i
  strobe on clock_i; reads are combinational on sfr_addr_i. peripherals
  present an output level, output enable and open-drain force per pin
  already ordered by the crossbar priority decoder outside this block.
*/
`timescale 1ns/10ps
`default_nettype none
`include "port_io_regs.vh"

//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////

module port_io_crossbar_config (
  input  wire        clock_i,
  input  wire        rst_n_i,
  input  wire [7:0]  sfr_addr_i,
  input  wire [7:0]  sfr_wdata_i,
  input  wire        sfr_wr_i,
  output reg  [7:0]  sfr_rdata_o,
  input  wire [15:0] periph_out_i,
  input  wire [15:0] periph_oe_i,
  input  wire [15:0] periph_smbus_i,
  output wire [15:0] periph_in_o,
  input  wire [15:0] pin_i,
  output reg  [15:0] pin_o,
  output reg  [15:0] pin_oe_n_o,
  output reg  [15:0] pin_pullup_o,
  output reg  [15:0] pin_analog_o,
  output wire [7:0]  route_matrix_cfg_a_o,
  output wire [7:0]  route_matrix_cfg_b_o,
  output wire        port0_mismatch_o,
  output wire        port1_mismatch_o
);

  //////////////////////////////////////////////////////////////////////////
  // configuration registers
  reg [7:0] port0_compare_value_r;
  reg [7:0] port1_compare_value_r;
  reg [7:0] port0_compare_select_r;
  reg [7:0] port1_compare_select_r;
  reg [7:0] port0_input_kind_r;
  reg [7:0] port1_input_kind_r;
  reg [7:0] port0_driver_kind_r;
  reg [7:0] port1_driver_kind_r;
  reg [7:0] port0_route_bypass_r;
  reg [7:0] port1_route_bypass_r;
  reg [7:0] route_matrix_cfg_a_r;
  reg [7:0] route_matrix_cfg_b_r;
  reg [7:0] route_matrix_cfg_c_r;
  reg [7:0] port0_data_r;
  reg [7:0] port1_data_r;

  // pin synchroniser, three stages; a change counts when 2 and 3 agree
  reg [15:0] pin_s1_r;
  reg [15:0] pin_s2_r;
  reg [15:0] pin_s3_r;
  reg [15:0] pin_level_r;

  wire        route_matrix_on = route_matrix_cfg_c_r[`BIT_ROUTE_MATRIX_ON];
  wire        pullup_off      = route_matrix_cfg_b_r[`BIT_PULLUP_OFF];
  wire [15:0] input_kind      = {port1_input_kind_r, port0_input_kind_r};
  wire [15:0] driver_kind     = {port1_driver_kind_r, port0_driver_kind_r};
  wire [15:0] route_bypass    = {port1_route_bypass_r, port0_route_bypass_r};
  wire [15:0] port_data       = {port1_data_r, port0_data_r};

  assign route_matrix_cfg_a_o = route_matrix_cfg_a_r;
  assign route_matrix_cfg_b_o = route_matrix_cfg_b_r;

  //////////////////////////////////////////////////////////////////////////
  // sfr write port; every register loads only on its own address
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port0_compare_value_r  <= `RST_COMPARE_VALUE;
      port1_compare_value_r  <= `RST_COMPARE_VALUE;
      port0_compare_select_r <= `RST_COMPARE_SELECT;
      port1_compare_select_r <= `RST_COMPARE_SELECT;
      port0_input_kind_r     <= `RST_INPUT_KIND;
      port1_input_kind_r     <= `RST_INPUT_KIND;
      port0_driver_kind_r    <= `RST_DRIVER_KIND;
      port1_driver_kind_r    <= `RST_DRIVER_KIND;
      port0_route_bypass_r   <= `RST_ROUTE_BYPASS;
      port1_route_bypass_r   <= `RST_ROUTE_BYPASS;
      route_matrix_cfg_a_r   <= `RST_MATRIX_CFG;
      route_matrix_cfg_b_r   <= `RST_MATRIX_CFG;
      route_matrix_cfg_c_r   <= `RST_MATRIX_CFG;
      port0_data_r           <= `RST_PORT_DATA;
      port1_data_r           <= `RST_PORT_DATA;
    end else if (sfr_wr_i) begin
      case (sfr_addr_i)
        `ADDR_PORT0_COMPARE_VALUE:  port0_compare_value_r  <= sfr_wdata_i;
        `ADDR_PORT1_COMPARE_VALUE:  port1_compare_value_r  <= sfr_wdata_i;
        `ADDR_PORT0_COMPARE_SELECT: port0_compare_select_r <= sfr_wdata_i;
        `ADDR_PORT1_COMPARE_SELECT: port1_compare_select_r <= sfr_wdata_i;
        `ADDR_PORT0_INPUT_KIND:     port0_input_kind_r     <= sfr_wdata_i;
        `ADDR_PORT1_INPUT_KIND:     port1_input_kind_r     <= sfr_wdata_i;
        `ADDR_PORT0_DRIVER_KIND:    port0_driver_kind_r    <= sfr_wdata_i;
        `ADDR_PORT1_DRIVER_KIND:    port1_driver_kind_r    <= sfr_wdata_i;
        `ADDR_PORT0_ROUTE_BYPASS:   port0_route_bypass_r   <= sfr_wdata_i;
        `ADDR_PORT1_ROUTE_BYPASS:   port1_route_bypass_r   <= sfr_wdata_i;
        `ADDR_ROUTE_MATRIX_CFG_A:   route_matrix_cfg_a_r   <= sfr_wdata_i;
        `ADDR_ROUTE_MATRIX_CFG_B:   route_matrix_cfg_b_r   <= sfr_wdata_i;
        `ADDR_ROUTE_MATRIX_CFG_C:   route_matrix_cfg_c_r   <= sfr_wdata_i;
        `ADDR_PORT0_DATA:           port0_data_r           <= sfr_wdata_i;
        `ADDR_PORT1_DATA:           port1_data_r           <= sfr_wdata_i;
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pin synchroniser; stage 1 feeds stage 2 only
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // reset to the pulled-up idle level so no false edge follows reset
      pin_s1_r    <= `RST_PIN_LEVEL;
      pin_s2_r    <= `RST_PIN_LEVEL;
      pin_s3_r    <= `RST_PIN_LEVEL;
      pin_level_r <= `RST_PIN_LEVEL;
    end else begin
      pin_s1_r <= pin_i;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      // a bit moves only when the last two stages agree
      pin_level_r <= (pin_s2_r & pin_s3_r) | (pin_level_r & (pin_s2_r | pin_s3_r));
    end
  end

  // analog pins have their receiver off and read as zero
  wire [15:0] pin_digital = pin_level_r & input_kind;
  assign periph_in_o = pin_digital;

  //////////////////////////////////////////////////////////////////////////
  // per-pin pad decode; one slice per pin, all slices registered below
  wire [15:0] pin_nxt;
  wire [15:0] pin_oe_n_nxt;
  wire [15:0] pin_pullup_nxt;
  wire [15:0] pin_analog_nxt;

  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_pin
      // skipped pins get no peripheral; they fall back to port data
      wire use_periph = periph_oe_i[g] & ~route_bypass[g];
      wire level      = use_periph ? periph_out_i[g] : port_data[g];
      wire open_drain = ~driver_kind[g] | (use_periph & periph_smbus_i[g]);
      wire digital    = input_kind[g];
      // crossbar off means every driver is released, pins are inputs
      wire drive_en   = route_matrix_on & digital & (~open_drain | ~level);
      wire drive_zero = drive_en & ~level;
      assign pin_nxt[g]        = level;
      assign pin_oe_n_nxt[g]   = ~drive_en;
      // pull-up only on open-drain digital pins not pulling low
      assign pin_pullup_nxt[g] = ~pullup_off & open_drain & digital & ~drive_zero;
      assign pin_analog_nxt[g] = ~digital;
    end
  endgenerate

  // pad flops; registered so pads never see decode glitches, at the cost
  // of one extra cycle between a register write and the pin
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_o        <= `RST_PAD_LEVEL;
      pin_oe_n_o   <= `RST_PAD_OE_N;   // all drivers released in reset
      pin_pullup_o <= `RST_PAD_PULLUP;
      pin_analog_o <= `RST_PAD_ANALOG;
    end else begin
      pin_o        <= pin_nxt;
      pin_oe_n_o   <= pin_oe_n_nxt;
      pin_pullup_o <= pin_pullup_nxt;
      pin_analog_o <= pin_analog_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // match comparison; unselected pins drop out of the compare
  assign port0_mismatch_o = |((pin_digital[7:0] ^ port0_compare_value_r)
                             & port0_compare_select_r);
  assign port1_mismatch_o = |((pin_digital[15:8] ^ port1_compare_value_r)
                             & port1_compare_select_r);

  //////////////////////////////////////////////////////////////////////////
  // sfr read mux; unmapped addresses read zero
  always @* begin
    case (sfr_addr_i)
      `ADDR_PORT0_COMPARE_VALUE:  sfr_rdata_o = port0_compare_value_r;
      `ADDR_PORT1_COMPARE_VALUE:  sfr_rdata_o = port1_compare_value_r;
      `ADDR_PORT0_COMPARE_SELECT: sfr_rdata_o = port0_compare_select_r;
      `ADDR_PORT1_COMPARE_SELECT: sfr_rdata_o = port1_compare_select_r;
      `ADDR_PORT0_INPUT_KIND:     sfr_rdata_o = port0_input_kind_r;
      `ADDR_PORT1_INPUT_KIND:     sfr_rdata_o = port1_input_kind_r;
      `ADDR_PORT0_DRIVER_KIND:    sfr_rdata_o = port0_driver_kind_r;
      `ADDR_PORT1_DRIVER_KIND:    sfr_rdata_o = port1_driver_kind_r;
      `ADDR_PORT0_ROUTE_BYPASS:   sfr_rdata_o = port0_route_bypass_r;
      `ADDR_PORT1_ROUTE_BYPASS:   sfr_rdata_o = port1_route_bypass_r;
      `ADDR_ROUTE_MATRIX_CFG_A:   sfr_rdata_o = route_matrix_cfg_a_r;
      `ADDR_ROUTE_MATRIX_CFG_B:   sfr_rdata_o = route_matrix_cfg_b_r;
      `ADDR_ROUTE_MATRIX_CFG_C:   sfr_rdata_o = route_matrix_cfg_c_r;
      `ADDR_PORT0_DATA:           sfr_rdata_o = pin_digital[7:0];  // reads the pin
      `ADDR_PORT1_DATA:           sfr_rdata_o = pin_digital[15:8];
      default:                    sfr_rdata_o = 8'h00;
    endcase
  end

endmodule // port_io_crossbar_config

`default_nettype wire

//--- bench/port_io_crossbar_config_checker.sv
/* checker: pad and register relations of the port block, on its ports only.
   assumes: bound to port_io_crossbar_config, single clock, async low reset. */
`timescale 1ns/10ps
`default_nettype none
module port_io_crossbar_config_checker (
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  sfr_addr_i,
  input wire logic [7:0]  sfr_wdata_i,
  input wire logic        sfr_wr_i,
  input wire logic [7:0]  sfr_rdata_o,
  input wire logic [15:0] periph_smbus_i,
  input wire logic [15:0] pin_o,
  input wire logic [15:0] pin_oe_n_o,
  input wire logic [15:0] pin_pullup_o,
  input wire logic [15:0] pin_analog_o,
  input wire logic        port0_mismatch_o,
  input wire logic        port1_mismatch_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // pads lag the bus by two edges: one into the register, one into the pad flop
  AST_ANALOG_QUIET: assert property ((pin_analog_o & (~pin_oe_n_o | pin_pullup_o)) == 16'h0)
    else $error("analog pin drives or pulls");
  AST_LOW_NO_PULL: assert property ((~pin_oe_n_o & ~pin_o & pin_pullup_o) == 16'h0)
    else $error("pull-up left on a pin driving low");
  AST_SMBUS_OD: assert property ((~pin_oe_n_o & pin_o & $past(periph_smbus_i)) == 16'h0)
    else $error("bus pin driven high");
  AST_XBAR_OFF: assert property (sfr_wr_i && sfr_addr_i == 8'he3 && !sfr_wdata_i[6]
    |-> ##2 pin_oe_n_o == 16'hffff) else $error("driver on with crossbar off");
  AST_PULL_OFF: assert property (sfr_wr_i && sfr_addr_i == 8'he2 && sfr_wdata_i[7]
    |-> ##2 pin_pullup_o == 16'h0) else $error("pull-up on after disable");
  AST_P0_VALUE: assert property (sfr_wr_i && sfr_addr_i == 8'hfd |=> sfr_addr_i != 8'hfd
    || sfr_rdata_o == $past(sfr_wdata_i)) else $error("port 0 match value lost");
  AST_P1_VALUE: assert property (sfr_wr_i && sfr_addr_i == 8'hed |=> sfr_addr_i != 8'hed
    || sfr_rdata_o == $past(sfr_wdata_i)) else $error("port 1 match value lost");
  AST_P0_QUIET: assert property (sfr_wr_i && sfr_addr_i == 8'hfe && sfr_wdata_i == 8'h0
    |=> !port0_mismatch_o) else $error("port 0 mismatch with nothing selected");
  AST_P1_QUIET: assert property (sfr_wr_i && sfr_addr_i == 8'hee && sfr_wdata_i == 8'h0
    |=> !port1_mismatch_o) else $error("port 1 mismatch with nothing selected");
  AST_RST_DIGITAL: assert property ($rose(rst_n_i) |-> ##1 pin_analog_o == 16'h0)
    else $error("pin analog after reset");
endmodule // port_io_crossbar_config_checker
bind port_io_crossbar_config port_io_crossbar_config_checker i_chk (.clock_i, .rst_n_i,
  .sfr_addr_i, .sfr_wdata_i, .sfr_wr_i, .sfr_rdata_o, .periph_smbus_i, .pin_o,
  .pin_oe_n_o, .pin_pullup_o, .pin_analog_o, .port0_mismatch_o, .port1_mismatch_o);
`default_nettype wire

//--- bench/pad_model.sv
/* pad model: resolves each package pin from device driver, outside source, pull-up.
   assumes: oe_n low means the device drives the pad. */
`timescale 1ns/10ps
`default_nettype none
module pad_model (
  input  wire logic        clock_i,
  input  wire logic [15:0] drv_i,
  input  wire logic [15:0] oe_n_i,
  input  wire logic [15:0] pull_i,
  input  wire logic [15:0] ext_i,
  input  wire logic [15:0] ext_en_i,
  output var  logic [15:0] pad_o
);
  logic [15:0] flt_r = 16'h5555;
  // floating pads wander every cycle so a stale level never reads as driven
  always @(posedge clock_i) flt_r <= ~flt_r;
  // device driver wins, then the outside source, then the weak pull-up
  always_comb
    for (int i = 0; i < 16; i++)
      pad_o[i] = !oe_n_i[i] ? drv_i[i] : ext_en_i[i] ? ext_i[i] : pull_i[i] | flt_r[i];
endmodule // pad_model
`default_nettype wire

//--- bench/port_io_crossbar_config_tb_top.sv
/* testbench: register rows, match, analog and crossbar cases on the port block.
   assumes: design, pad model and checker compiled before this file. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module port_io_crossbar_config_tb_top;
  logic        clock_i, rst_n_i, wr, mm0, mm1;
  logic [7:0]  addr, wdata, rdata, cfg_a, cfg_b;
  logic [15:0] p_out, p_oe, smb, ext, ext_en, p_in, pin, oe_n, pull, ana, pad;
  int          mismatches, n_tests, cyc;
  logic [23:0] rows [9] = '{24'hfd5a5a, 24'heda5a5, 24'he13c3c, 24'h7f1100, 24'hd40101,
                            24'hd53c3c, 24'hf2ffff, 24'ha50101, 24'h90ffff};
  port_io_crossbar_config i_port_io_crossbar_config (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .sfr_addr_i(addr), .sfr_wdata_i(wdata), .sfr_wr_i(wr), .sfr_rdata_o(rdata),
    .periph_out_i(p_out), .periph_oe_i(p_oe), .periph_smbus_i(smb), .periph_in_o(p_in),
    .pin_i(pad), .pin_o(pin), .pin_oe_n_o(oe_n), .pin_pullup_o(pull), .pin_analog_o(ana),
    .route_matrix_cfg_a_o(cfg_a), .route_matrix_cfg_b_o(cfg_b),
    .port0_mismatch_o(mm0), .port1_mismatch_o(mm1));
  pad_model i_pad_model (.clock_i(clock_i), .drv_i(pin), .oe_n_i(oe_n), .pull_i(pull),
    .ext_i(ext), .ext_en_i(ext_en), .pad_o(pad));
  ////////////////////////////////////////////////////////////////////////////////
  // bus tasks: change at the falling edge; writes taken at the next rising edge, reads checked 1 ns later
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    {addr, wdata, wr} = {a, d, 1'b1};
    @(negedge clock_i);
    wr = 1'b0;
  endtask
  task automatic r(input logic [7:0] a, input logic [7:0] e);
    @(negedge clock_i);
    addr = a;
    #1 `CHK("rdata", e, rdata)
  endtask
  task automatic t(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard; whole run is about 120 cycles
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      wrap_up();
    end
  end
  // main sequence
  initial begin
    {rst_n_i, wr, addr, wdata, p_out, p_oe, smb} = '0;
    {ext, ext_en} = {16'hffff, 16'hffff};
    repeat (8) @(posedge clock_i);
    #1 `CHK("oe_n", 16'hffff, oe_n)
    @(negedge clock_i) rst_n_i = 1'b1;
    t(2);
    r(8'hfd, 8'hff);
    r(8'hed, 8'hff);
    r(8'hf1, 8'hff);
    `CHK("analog", 16'h0, ana)
    `CHK("pull", 16'hffff, pull)
    done("reset");
    // register rows, the unmapped one reads zero
    foreach (rows[i]) begin
      w(rows[i][23:16], rows[i][15:8]);
      r(rows[i][23:16], rows[i][7:0]);
    end
    `CHK("cfg_a", 8'h3c, cfg_a)
    `CHK("oe_n", 16'hffff, oe_n)
    done("rows");
    // pin 0 and pin 15 low; pin 1 low but never selected
    w(8'hfe, 8'h01);
    w(8'hee, 8'h80);
    w(8'hfd, 8'hff);
    w(8'hed, 8'hff);
    ext = 16'h7ffc;
    t(6);
    `CHK("mm0", 1'b1, mm0)
    `CHK("mm1", 1'b1, mm1)
    w(8'hfd, 8'hfe);
    w(8'hed, 8'h7f);
    t(2);
    `CHK("mm0", 1'b0, mm0)
    `CHK("mm1", 1'b0, mm1)
    w(8'hfe, 8'h00);
    w(8'hee, 8'h00);
    ext = 16'hffff;
    done("match");
    // configure in order: input kind, driver kind, bypass, then crossbar on
    w(8'hf1, 8'hfe);
    t(6);
    `CHK("analog", 16'h0001, ana)
    `CHK("p_in0", 1'b0, p_in[0])
    `CHK("pull", 16'hfefe, pull)
    done("analog");
    // pin 5 held low, then released so only its weak pull-up lifts it
    ext = 16'hffdf;
    t(6);
    `CHK("p_in5", 1'h0, p_in[5])
    ext_en = 16'hffdf;
    t(6);
    `CHK("p_in5", 1'h1, p_in[5])
    {ext, ext_en} = {16'hffff, 16'hffff};
    done("pullup");
    // pin 4 is claimed by a peripheral but skipped, so it keeps port data
    w(8'ha4, 8'h0c);
    w(8'hd4, 8'h11);
    {p_out, p_oe, smb} = {16'h000c, 16'h001e, 16'h0004};
    w(8'he3, 8'h40);
    t(3);
    `CHK("oe_n", 16'hfef5, oe_n)
    `CHK("oe_n1", 1'h0, oe_n[1])
    `CHK("oe_n4", 1'h1, oe_n[4])
    `CHK("pin31", 2'h2, {pin[3], pin[1]})
    `CHK("pull", 16'hfef4, pull)
    w(8'he2, 8'h80);
    t(3);
    `CHK("pull", 16'h0, pull)
    `CHK("cfg_b", 8'h80, cfg_b)
    w(8'he3, 8'h00);
    t(3);
    `CHK("oe_n", 16'hffff, oe_n)
    // port data low must not reach the pins while the crossbar is off
    w(8'h80, 8'h00);
    t(3);
    `CHK("oe_n", 16'hffff, oe_n)
    r(8'h80, 8'hfe);
    done("crossbar");
    // second reset in mid-run
    @(negedge clock_i) rst_n_i = 1'b0;
    #1 `CHK("oe_n", 16'hffff, oe_n)
    `CHK("analog", 16'h0, ana)
    @(negedge clock_i) rst_n_i = 1'b1;
    r(8'hfd, 8'hff);
    r(8'hf1, 8'hff);
    t(2);
    `CHK("pull", 16'hffff, pull)
    done("reset2");
    wrap_up();
  end
endmodule // port_io_crossbar_config_tb_top
`default_nettype wire
